// [core/mcu_interrupt_request_logic.sv]
/*
 Request flags, enables, group summary flags and dispatch of the
 second and third multi-function interrupt groups.
 Assumes the core pulses its boundary, call, return and interrupt-return
 strobes on the same clock, and that event inputs are one-cycle pulses.
*/
// Implementation choices: the register offsets and strobed register access.
`include "irq_cfg.svh"
`default_nettype none
module mcu_interrupt_request_logic
   import irq_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [`IRQ_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic extPeriphEvent,
   input wire logic serialEvent,
   input wire logic timer3CmpAEvent,
   input wire logic timer3CmpPEvent,
   input wire logic secondSpiEvent,
   input wire logic eepromDoneEvent,
   input wire logic lowVoltageEvent,
   input wire logic cpuBoundary,
   input wire pc_t cpuNextPc,
   input wire logic cpuCall,
   input wire logic cpuRet,
   input wire logic cpuReti,
   input wire logic cpuSleeping,
   output logic pcLoad,
   output pc_t pcLoadAddr,
   output logic wakeUp
);
   // Enable for flag bit i+4 lives at bit i in both groups
   function automatic logic groupHit(input logic [7:0] setVec, input logic [7:0] regVal);
      groupHit = |(setVec[7:4] & regVal[3:0]);
   endfunction

   function automatic logic freshSet(input logic [7:0] setVec, input logic [7:0] regVal);
      freshSet = |(setVec & ~regVal);
   endfunction

   disp_state_e state;
   disp_state_e next_state;
   logic [7:0] group2;
   logic [7:0] group3;
   logic globalEnable;
   logic mf2Enable;
   logic mf3Enable;
   logic mf2Flag;
   logic mf3Flag;
   pc_t stackTop;
   logic [`IRQ_SP_W-1:0] stackDepth;
   logic stackFull;

   wire [7:0] mask2 = LARGE_VARIANT ? `IRQ_MASK_G2_LARGE : `IRQ_MASK_G2_SMALL;
   wire [7:0] mask3 = `IRQ_MASK_G3;

   wire [7:0] rawSet2 = {timer3CmpAEvent, timer3CmpPEvent, extPeriphEvent,
                         serialEvent, 4'h0};
   wire [7:0] rawSet3 = {1'b0, secondSpiEvent, eepromDoneEvent, lowVoltageEvent, 4'h0};
   wire [7:0] hwSet2 = rawSet2 & mask2;
   wire [7:0] hwSet3 = rawSet3 & mask3;

   wire selCtrl = (regAddr == `IRQ_OFF_CTRL);
   wire selG2 = (regAddr == `IRQ_OFF_GROUP2);
   wire selG3 = (regAddr == `IRQ_OFF_GROUP3);
   wire selSum = (regAddr == `IRQ_OFF_SUMMARY);
   wire wrCtrl = regWr && selCtrl;
   wire wrG2 = regWr && selG2;
   wire wrG3 = regWr && selG3;
   wire wrSum = regWr && selSum;

   // write then hardware set, set wins
   wire [7:0] next_group2 = ((wrG2 ? regWrData : group2) | hwSet2) & mask2;
   wire [7:0] next_group3 = ((wrG3 ? regWrData : group3) | hwSet3) & mask3;

   // enabled source feeds its group flag
   wire mf2Set = groupHit(hwSet2, group2);
   wire mf3Set = groupHit(hwSet3, group3);

   wire req2 = mf2Flag && mf2Enable;
   wire req3 = mf3Flag && mf3Enable;
   wire anyReturn = cpuRet || cpuReti;
   wire cpuBusy = cpuCall || anyReturn;

   wire take = (state == ST_RUN) && cpuBoundary && !cpuBusy && globalEnable &&
               !stackFull && (req2 || req3);
   // group 2 ahead of group 3
   wire takeMf2 = take && req2;
   wire takeMf3 = take && !req2;
   wire pc_t vecSel = req2 ? `IRQ_VEC_MF2 : `IRQ_VEC_MF3;
   wire doReturn = (state == ST_RUN) && anyReturn;

   // service clears group flag unless set again
   wire next_mf2Flag = mf2Set || (!takeMf2 && (wrSum ? regWrData[`IRQ_SUM_MF2F] : mf2Flag));
   wire next_mf3Flag = mf3Set || (!takeMf3 && (wrSum ? regWrData[`IRQ_SUM_MF3F] : mf3Flag));

   // entry clears global enable; interrupt return restores it, plain return does not
   wire next_globalEnable = take ? 1'b0 :
                            wrCtrl ? regWrData[`IRQ_CTRL_GIE] :
                            (cpuReti && doReturn) ? 1'b1 : globalEnable;

   // only a flag going from clear to set wakes
   wire next_wakeUp = cpuSleeping && (freshSet(hwSet2, group2) || freshSet(hwSet3, group3));

   wire pc_t next_pcLoadAddr = take ? vecSel : doReturn ? stackTop : pcLoadAddr;
   wire next_pcLoad = take || doReturn;

   wire [7:0] ctrlView = {stackFull, 6'h00, globalEnable};
   wire [7:0] sumView = {2'h0, mf3Flag, mf2Flag, 2'h0, mf3Enable, mf2Enable};
   wire [7:0] rdMux = selCtrl ? ctrlView :
                      selG2 ? group2 :
                      selG3 ? group3 :
                      selSum ? sumView : 8'h00;
   wire [7:0] next_regRdData = regRd ? rdMux : 8'h00;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (next_pcLoad) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // address pushed on entry, popped on return
   irq_ret_stack u_stack (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .push(take || (cpuCall && cpuBoundary && state == ST_RUN)),
      .pop(doReturn),
      .pushAddr(cpuNextPc),
      .topAddr(stackTop),
      .depth(stackDepth),
      .full(stackFull)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_RUN;
         group2 <= `IRQ_REG_RESET;
         group3 <= `IRQ_REG_RESET;
         globalEnable <= 1'b0;
         mf2Enable <= 1'b0;
         mf3Enable <= 1'b0;
         mf2Flag <= 1'b0;
         mf3Flag <= 1'b0;
      end else begin
         state <= next_state;
         group2 <= next_group2;
         group3 <= next_group3;
         globalEnable <= next_globalEnable;
         mf2Flag <= next_mf2Flag;
         mf3Flag <= next_mf3Flag;
         if (wrSum) begin
            mf2Enable <= regWrData[`IRQ_SUM_MF2E];
            mf3Enable <= regWrData[`IRQ_SUM_MF3E];
         end
      end
   end

   // vector or return address drives the counter
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pcLoad <= 1'b0;
         pcLoadAddr <= '0;
         wakeUp <= 1'b0;
         regRdData <= 8'h00;
      end else begin
         pcLoad <= next_pcLoad;
         pcLoadAddr <= next_pcLoadAddr;
         wakeUp <= next_wakeUp;
         regRdData <= next_regRdData;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   AST_UNUSED_ZERO: assert property (
      group3[7] == 1'b0 && group3[3] == 1'b0 && (group2 & ~mask2) == 8'h00)
      else $error("unimplemented group bit is set");

   AST_EVENT_SETS: assert property (
      extPeriphEvent |=> group2[`IRQ_G2_XPF])
      else $error("peripheral event did not set its flag");

   AST_SPI_SETS: assert property (
      secondSpiEvent |=> group3[`IRQ_G3_SPIF])
      else $error("spi event did not set its flag");

   AST_DISABLED_NO_GROUP: assert property (
      (hwSet2 != 8'h00) && !groupHit(hwSet2, group2) && !mf2Flag &&
      !(wrSum && regWrData[`IRQ_SUM_MF2F]) |=> !mf2Flag)
      else $error("disabled source raised group flag");

   AST_GIE_BLOCKS: assert property (
      !globalEnable && !anyReturn |=> !pcLoad)
      else $error("interrupt taken with global enable clear");

   AST_PUSH_ON_TAKE: assert property (
      take |=> stackDepth == $past(stackDepth) + `IRQ_SP_W'(1))
      else $error("stack not pushed on entry");

   AST_VECTOR_LOAD: assert property (
      take |=> pcLoad && pcLoadAddr == $past(vecSel) ##1 !pcLoad)
      else $error("vector load wrong or not a single pulse");

   AST_RETURN_POP: assert property (
      doReturn && stackDepth != '0 |=> pcLoad && pcLoadAddr == $past(stackTop))
      else $error("return did not restore saved address");

   AST_GIE_CLEARED: assert property (
      take |=> !globalEnable)
      else $error("global enable survived entry");

   AST_FULL_BLOCKS: assert property (
      stackFull && !anyReturn |=> !pcLoad)
      else $error("request acknowledged with full stack");

   AST_PRIORITY: assert property (
      take && req2 && req3 |=> pcLoadAddr == `IRQ_VEC_MF2 ##1 mf3Flag)
      else $error("lower group served first");

   AST_WAKE: assert property (
      cpuSleeping && extPeriphEvent && !group2[`IRQ_G2_XPF] |=> wakeUp)
      else $error("fresh flag did not wake");

   AST_NO_WAKE_PRESET: assert property (
      cpuSleeping && freshSet(hwSet2, group2) == 1'b0 &&
      freshSet(hwSet3, group3) == 1'b0 |=> !wakeUp)
      else $error("wake without a fresh flag");

   AST_GROUP_CLEAR: assert property (
      takeMf2 && !mf2Set && !wrG2 |=>
      !mf2Flag && ((group2 & $past(group2)) == $past(group2)))
      else $error("group flag not cleared or source flag lost on service");

   AST_SERIAL_SETS: assert property (
      serialEvent |=> group2[`IRQ_G2_SERIAL_MODULE_REQ_FLAG])
      else $error("serial event did not set its flag");

   AST_TIMER_A_SETS: assert property (
      LARGE_VARIANT && timer3CmpAEvent |=> group2[`IRQ_G2_TIMER3_CMP_A_FLAG])
      else $error("timer comparator A event did not set its flag");

   AST_TIMER_P_SETS: assert property (
      LARGE_VARIANT && timer3CmpPEvent |=> group2[`IRQ_G2_TIMER3_CMP_P_FLAG])
      else $error("timer comparator P event did not set its flag");

   AST_EEPROM_SETS: assert property (
      eepromDoneEvent |=> group3[`IRQ_G3_DEF])
      else $error("eeprom event did not set its flag");

   AST_LOWV_SETS: assert property (
      lowVoltageEvent |=> group3[`IRQ_G3_LVF])
      else $error("low voltage event did not set its flag");

   AST_SMALL_MAP: assert property (
      !LARGE_VARIANT |-> group2[7:6] == 2'h0 && group2[3:2] == 2'h0)
      else $error("small map holds timer bits");

   AST_UNMAPPED_READ: assert property (
      regRd && !(selCtrl || selG2 || selG3 || selSum) |=> regRdData == 8'h00)
      else $error("unmapped index read nonzero");

   AST_G3_WRITE: assert property (
      wrG3 && hwSet3 == 8'h00 |=> group3 == ($past(regWrData) & `IRQ_MASK_G3))
      else $error("group3 write kept unused bits");

   AST_G2_WRITE: assert property (
      wrG2 && hwSet2 == 8'h00 |=> group2 == ($past(regWrData) & mask2))
      else $error("group2 write not taken next cycle");

   AST_READ_G2: assert property (
      regRd && selG2 |=> regRdData == $past(group2))
      else $error("group2 read data wrong");

   AST_NO_ENABLE_NO_LOAD: assert property (
      !mf2Enable && !mf3Enable && !anyReturn |=> !pcLoad)
      else $error("interrupt taken with both groups disabled");

   AST_GROUP3_FROM_SOURCE: assert property (
      eepromDoneEvent && group3[`IRQ_G3_DEE] |=> mf3Flag)
      else $error("enabled source did not raise group3 flag");

   AST_GROUP2_FROM_SOURCE: assert property (
      serialEvent && group2[`IRQ_G2_SERIAL_MODULE_REQ_ENABLE] |=> mf2Flag)
      else $error("enabled source did not raise group2 flag");

   AST_LATCHED_WHILE_OFF: assert property (
      !globalEnable && mf3Flag && !wrSum |=> mf3Flag)
      else $error("request lost while global enable clear");

   AST_NESTED_TAKE: assert property (
      globalEnable && req2 && cpuBoundary && !cpuBusy && !stackFull &&
      state == ST_RUN |=> pcLoad && pcLoadAddr == `IRQ_VEC_MF2)
      else $error("enabled request refused while global enable set");

   AST_RETURN_FROM_IRQ_INSTR_ENABLES: assert property (
      cpuReti && state == ST_RUN && !wrCtrl |=> globalEnable)
      else $error("interrupt return did not restore global enable");

   AST_RETURN_PULSE: assert property (
      doReturn |=> pcLoad ##1 !pcLoad)
      else $error("return load not a single pulse");

   AST_SP_BOUND: assert property (
      stackDepth <= `IRQ_SP_W'(`IRQ_STACK_DEPTH))
      else $error("stack grew beyond its depth");

   AST_FULL_STAYS: assert property (
      stackFull && !anyReturn |=> stackFull)
      else $error("full stack shrank without a return");

   AST_GROUP3_VECTOR: assert property (
      take && !req2 |=> pcLoadAddr == `IRQ_VEC_MF3)
      else $error("group3 served with wrong vector");

   AST_SERVE_CLEAR3: assert property (
      takeMf3 && !mf3Set |=> !mf3Flag)
      else $error("group3 flag not cleared on service");

   AST_WAKE_G3: assert property (
      cpuSleeping && lowVoltageEvent && !group3[`IRQ_G3_LVF] |=> wakeUp)
      else $error("fresh group3 flag did not wake");

   AST_AWAKE_QUIET: assert property (
      !cpuSleeping |=> !wakeUp)
      else $error("wake pulse while running");

   AST_LOAD_PULSE: assert property (
      pcLoad |=> !pcLoad)
      else $error("counter load longer than one cycle");
endmodule
`default_nettype wire

// [core/irq_cfg.svh]
/*
 Offsets, field positions, reset values and vectors of the interrupt block.
 Assumes inclusion by bare name from the package and design files.
*/
// Functional notes
// - Small group2: bit5 external peripheral flag, bit1 its enable.
// - Group2: bit4 serial module flag, bit0 its enable.
// - Large group2: bits7/6 timer3 A/P flags, bits3/2 their enables.
// - Unimplemented group bits read zero and ignore writes.
// - Group3: bit6 second SPI flag, bit2 enable; bits7 and 3 unused.
// - Group3: bit5 EEPROM done flag, bit1 its enable.
// - Group3: bit4 low-voltage flag, bit0 its enable.
// - Source event sets its flag whatever the enable.
// - Set flag dispatches only when its enable is one.
// - Global enable low blocks every interrupt.
// - Taking an interrupt pushes the next-instruction address onto the stack.
// - Then the program counter loads the serviced vector.
// - Return-from-interrupt pops the saved address back into the counter.
// - Servicing clears the global enable automatically.
// - Requests during service stay latched and are taken later.
// - Global enable set inside service allows a nested interrupt.
// - Full stack blocks all acknowledgement until it shrinks.
// - Simultaneous requests follow fixed priority.
// - Any flag becoming set wakes the device from sleep or idle; here only a source event setting a clear source flag wakes.
// - Flag already set before sleep causes no wake-up.
// - Group summary flag sets when a contained source flag sets; this block sets it only if that source's enable is already one.
// - Servicing clears the group summary flag, source flags stay.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
`define IRQ_ADDR_W 4
`define IRQ_PC_W 12
`define IRQ_STACK_DEPTH 8
`define IRQ_SP_W 4
`define IRQ_OFF_CTRL 4'h0
`define IRQ_OFF_GROUP2 4'h1
`define IRQ_OFF_GROUP3 4'h2
`define IRQ_OFF_SUMMARY 4'h3
`define IRQ_CTRL_GIE 0
`define IRQ_CTRL_FULL 7
`define IRQ_SUM_MF2E 0
`define IRQ_SUM_MF3E 1
`define IRQ_SUM_MF2F 4
`define IRQ_SUM_MF3F 5
`define IRQ_G2_TIMER3_CMP_A_FLAG 7
`define IRQ_G2_TIMER3_CMP_P_FLAG 6
`define IRQ_G2_XPF 5
`define IRQ_G2_SERIAL_MODULE_REQ_FLAG 4
`define IRQ_G2_XPE 1
`define IRQ_G2_SERIAL_MODULE_REQ_ENABLE 0
`define IRQ_G3_SPIF 6
`define IRQ_G3_DEF 5
`define IRQ_G3_LVF 4
`define IRQ_G3_SPIE 2
`define IRQ_G3_DEE 1
`define IRQ_G3_LVE 0
`define IRQ_MASK_G2_SMALL 8'h33
`define IRQ_MASK_G2_LARGE 8'hFF
`define IRQ_MASK_G3 8'h77
`define IRQ_REG_RESET 8'h00
`define IRQ_VEC_MF2 12'h020
`define IRQ_VEC_MF3 12'h02C
`endif

// [core/irq_pkg.sv]
/*
 Types shared by the interrupt block.
 Assumes the constants header is on the include path.
*/
`include "irq_cfg.svh"
`default_nettype none
package irq_pkg;
   typedef logic [`IRQ_PC_W-1:0] pc_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'h1,
      ST_LOAD = 2'h2
   } disp_state_e;
endpackage
`default_nettype wire

// [core/irq_ret_stack.sv]
/*
 Hardware return-address stack with push, pop and full indication.
 Assumes push and pop never arrive in the same cycle.
*/
`include "irq_cfg.svh"
`default_nettype none
module irq_ret_stack
   import irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic pop,
   input wire pc_t pushAddr,
   output pc_t topAddr,
   output logic [`IRQ_SP_W-1:0] depth,
   output logic full
);
   pc_t mem [`IRQ_STACK_DEPTH];
   logic [`IRQ_SP_W-1:0] sp;
   wire doPush = push && !full;
   wire doPop = pop && (sp != '0);
   wire [`IRQ_SP_W-1:0] topIdx = sp - `IRQ_SP_W'(1);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sp <= '0;
      end else if (doPush) begin
         sp <= sp + `IRQ_SP_W'(1);
      end else if (doPop) begin
         sp <= topIdx;
      end
   end

   // Storage carries no reset; only the pointer defines validity
   always_ff @(posedge sys_clk) begin
      if (doPush) begin
         mem[sp[`IRQ_SP_W-2:0]] <= pushAddr;
      end
   end

   assign topAddr = (sp == '0) ? pc_t'(0) : mem[topIdx[`IRQ_SP_W-2:0]];
   assign depth = sp;
   assign full = (sp == `IRQ_SP_W'(`IRQ_STACK_DEPTH));
endmodule
`default_nettype wire

// [tb/cpu_core_model.sv]
/*
 Processor core model: program counter, call and return strobes, stall, sleep.
 Assumes the bench drives cmd, hold and sleep right after rising edges.
*/
`include "irq_cfg.svh"
`default_nettype none
module cpu_core_model
   import irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [1:0] cmd,
   input wire logic hold,
   input wire logic sleep,
   input wire logic pcLoad,
   input wire pc_t pcLoadAddr,
   output logic cpuBoundary,
   output pc_t cpuNextPc,
   output logic cpuCall,
   output logic cpuRet,
   output logic cpuReti,
   output logic cpuSleeping
);
   timeunit 1ns;
   timeprecision 1ps;
   pc_t pc;
   // Hold models a slow core with no instruction boundary
   assign cpuBoundary = !hold && !sys_rst;
   assign cpuNextPc = pc;
   assign cpuCall = (cmd == 2'h1);
   assign cpuRet = (cmd == 2'h2);
   assign cpuReti = (cmd == 2'h3);
   assign cpuSleeping = sleep;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pc <= 12'h100;
      end else if (pcLoad) begin
         pc <= pcLoadAddr;
      end else if (!hold) begin
         pc <= pc + 12'h001;
      end
   end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
 Self-checking bench: register tasks, event pulses, dispatch and returns.
 Assumes the core model; a second instance carries the small group2 map.
*/
`include "irq_cfg.svh"
`default_nettype none
module tb_top import irq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] CTRL = `IRQ_OFF_CTRL;
   localparam logic [3:0] G2 = `IRQ_OFF_GROUP2;
   localparam logic [3:0] G3 = `IRQ_OFF_GROUP3;
   localparam logic [3:0] SUM = `IRQ_OFF_SUMMARY;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [6:0] events = 7'h00;
   logic [1:0] cmd = 2'h0;
   logic hold = 1'b0;
   logic sleep = 1'b0;
   logic [7:0] regRdData;
   logic [7:0] smallRdData;
   logic cpuBoundary, cpuCall, cpuRet, cpuReti, cpuSleeping, pcLoad, wakeUp;
   pc_t cpuNextPc, pcLoadAddr, prevPc;
   pc_t stk[$];
   int failCount = 0, checkCount = 0, loadCount = 0, wakeCount = 0;
   logic [3:0] evAddr [7] = '{G3, G3, G3, G2, G2, G2, G2};
   logic [7:0] evBit [7] = '{8'h10, 8'h20, 8'h40, 8'h40, 8'h80, 8'h10, 8'h20};
   always #25 sys_clk = ~sys_clk;
   mcu_interrupt_request_logic #(.LARGE_VARIANT(1'b1)) dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .extPeriphEvent(events[6]),
      .serialEvent(events[5]), .timer3CmpAEvent(events[4]), .timer3CmpPEvent(events[3]),
      .secondSpiEvent(events[2]), .eepromDoneEvent(events[1]),
      .lowVoltageEvent(events[0]), .cpuBoundary(cpuBoundary), .cpuNextPc(cpuNextPc),
      .cpuCall(cpuCall), .cpuRet(cpuRet), .cpuReti(cpuReti), .cpuSleeping(cpuSleeping),
      .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .wakeUp(wakeUp));
   cpu_core_model core0 (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .hold(hold),
      .sleep(sleep), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr),
      .cpuBoundary(cpuBoundary), .cpuNextPc(cpuNextPc), .cpuCall(cpuCall),
      .cpuRet(cpuRet), .cpuReti(cpuReti), .cpuSleeping(cpuSleeping));
   // Small map shares every stimulus; only its read port is compared
   mcu_interrupt_request_logic #(.LARGE_VARIANT(1'b0)) dutSmall (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(smallRdData), .extPeriphEvent(events[6]),
      .serialEvent(events[5]), .timer3CmpAEvent(events[4]), .timer3CmpPEvent(events[3]),
      .secondSpiEvent(events[2]), .eepromDoneEvent(events[1]),
      .lowVoltageEvent(events[0]), .cpuBoundary(cpuBoundary), .cpuNextPc(cpuNextPc),
      .cpuCall(cpuCall), .cpuRet(cpuRet), .cpuReti(cpuReti), .cpuSleeping(cpuSleeping),
      .pcLoad(), .pcLoadAddr(), .wakeUp());
   // Address the core offered at the last edge, i.e. what a push saw
   always @(posedge sys_clk) begin
      prevPc <= cpuNextPc;
      if (pcLoad === 1'b1) loadCount++;
      if (wakeUp === 1'b1) wakeCount++;
   end
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk({4'h0, regRdData}, {4'h0, e});
   endtask
   task automatic ev(input int i);
      @(posedge sys_clk);
      events[i] <= 1'b1;
      @(posedge sys_clk);
      events[i] <= 1'b0;
   endtask
   task automatic quiet(input int n);
      int n0;
      n0 = loadCount;
      repeat (n) @(posedge sys_clk);
      #1;
      chk(12'(loadCount - n0), 12'h000);
   endtask
   // Masking by pcLoad makes a missing pulse a mismatch
   task automatic waitLoad(input pc_t e);
      for (int k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         #1;
         if (pcLoad === 1'b1) break;
      end
      chk(pcLoadAddr & {12{pcLoad}}, e);
      stk.push_back(prevPc);
   endtask
   task automatic core(input logic [1:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 2'h0;
      #1;
      if (c == 2'h1) stk.push_back(prevPc);
      else chk(pcLoadAddr & {12{pcLoad}}, stk.pop_back());
   endtask
   task automatic wake(input int i, input int e);
      int n0;
      n0 = wakeCount;
      ev(i);
      @(posedge sys_clk);
      #1;
      chk(12'(wakeCount - n0), 12'(e));
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      failCount++;
      endOfTest();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 5; a++) rdChk(4'(a), 8'h00);
      wr(G2, 8'hFF);
      rdChk(G2, 8'hFF);
      chk({4'h0, smallRdData}, {4'h0, `IRQ_MASK_G2_SMALL});
      wr(G3, 8'hFF);
      rdChk(G3, 8'h77);
      wr(4'hE, 8'hFF);
      rdChk(4'hE, 8'h00);
      wr(G2, 8'h00);
      wr(G3, 8'h00);
      wr(SUM, 8'h00);
      for (int i = 0; i < 7; i++) begin
         ev(i);
         rdChk(evAddr[i], evBit[i]);
         chk({4'h0, smallRdData},
            {4'h0, evBit[i] & (evAddr[i] == G2 ? `IRQ_MASK_G2_SMALL : `IRQ_MASK_G3)});
         wr(evAddr[i], 8'h00);
      end
      wr(G2, 8'h02);
      wr(SUM, 8'h03);
      ev(6);
      rdChk(SUM, 8'h13);
      ev(0);
      rdChk(SUM, 8'h13);
      quiet(4);
      @(posedge sys_clk);
      hold <= 1'b1;
      wr(CTRL, 8'h01);
      quiet(4);
      @(posedge sys_clk);
      hold <= 1'b0;
      waitLoad(`IRQ_VEC_MF2);
      rdChk(CTRL, 8'h00);
      rdChk(SUM, 8'h03);
      rdChk(G2, 8'h22);
      wr(G3, 8'h11);
      ev(0);
      ev(6);
      quiet(3);
      rdChk(SUM, 8'h33);
      wr(CTRL, 8'h01);
      waitLoad(`IRQ_VEC_MF2);
      core(2'h3);
      waitLoad(`IRQ_VEC_MF3);
      core(2'h3);
      core(2'h3);
      repeat (8) core(2'h1);
      rdChk(CTRL, 8'h81);
      ev(6);
      quiet(5);
      core(2'h2);
      waitLoad(`IRQ_VEC_MF2);
      @(posedge sys_clk);
      sleep <= 1'b1;
      wake(6, 0);
      wake(5, 1);
      endOfTest();
   end
endmodule
`default_nettype wire
